//--- rtl/rpg_access_if.sv
// Access descriptor for the region checker
`timescale 1ns/1ns
interface rpg_access_if import rpg_pkg::*; ();
  logic        valid;
  logic [19:0] addr;
  rpg_kind_t   kind;
  logic        denied;

  modport src (output valid, output addr, output kind, input denied);
  modport chk (input valid, input addr, input kind, output denied);
endinterface

//--- rtl/rpg_guard.sv
// RAM parity, write guards and illegal access detect
//
// Summary of operation
// (R1) Byte parity stored on write, checked on read
// (R2) Parity check always on, only reset maskable
// (R3) Mask bit 7: 0 resets, 1 no reset
// (R4) Parity reset enabled after any reset
// (R5) Error flag bit 0 set on every error
// (R6) Flag cleared by writing 0 or reset
// (R7) Flag stays set over good reads
// (R8) Fetches and lookahead reads are checked too
// (R9) Software initialises used RAM plus ten bytes
// (R10) Parity control takes bit and byte writes
// (R11) Guarded RAM: writes dropped, reads served
// (R12) Guard size 00 none, 128/256/512 bytes
// (R13) General register area never write guarded
// (R14) Port guard blocks port control writes
// (R15) Port output data writes always pass
// (R16) Interrupt guard blocks interrupt register writes
// (R17) Clock guard blocks clock, voltage, parity writes
// (R18) Prohibited access raises internal reset
// (R19) Detect enable set-only until reset
// (R20) Watchdog option forces detection on
// (R21) Access guard resets zero, byte writes only
// (R22) Region bounds follow product flash and RAM
// (R23) Blocked writes dropped silently, no flag
// (R24) Region permissions from a configurable table
// (R25) Unused bits read zero, ignore writes
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ns
module rpg_guard import rpg_pkg::*; #(
  parameter logic [19:0] RAM_START = RPG_RAM_START,
  parameter int          RAM_BYTES = RPG_RAM_BYTES,
  parameter int          IDX_W     = $clog2(RAM_BYTES)
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Avalon-MM register slave
  input  wire logic [21:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic [1:0]       avs_response,
  output logic             avs_waitrequest,
  // CPU access port
  input  wire logic        cpu_req,
  input  wire rpg_kind_t   cpu_kind,
  input  wire logic [19:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  output logic [7:0]       cpu_rdata,
  output logic             cpu_rvalid,
  // RAM side
  output logic             ram_we,
  output logic             ram_re,
  output logic [IDX_W-1:0] ram_addr,
  output logic [7:0]       ram_wdata,
  input  wire logic [7:0]  ram_rdata,
  // SFR write forwarding
  output logic             sfr_we,
  output logic [19:0]      sfr_addr,
  output logic [7:0]       sfr_wdata,
  // Option strap and reset request
  input  wire logic        watchdog_option_on,
  output logic             internal_reset_req,
  output logic             parity_reset_evt,
  output logic             access_reset_evt
);

  // ========================================
  // Reset release synchroniser
  logic rst_meta_n;
  logic rst_core_n;

  // Two-edge release, all flops leave together
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_core_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_core_n <= rst_meta_n;
    end
  end

  // ========================================
  // Option strap synchroniser
  logic wdt_meta;
  logic wdt_on;

  // Strap is a pin: two stages first
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      wdt_meta <= 1'b0;
      wdt_on   <= 1'b0;
    end else begin
      wdt_meta <= watchdog_option_on;
      wdt_on   <= wdt_meta;
    end
  end

  // ========================================
  // Control registers
  logic       parity_reset_mask;
  logic       parity_error_flag;
  logic       illegal_access_detect_enable;
  logic [1:0] ram_guard_size;
  logic       port_ctrl_write_guard;
  logic       irq_reg_write_guard;
  logic       clock_volt_parity_guard;
  logic       parity_err_evt;

  // ========================================
  // Avalon slave handshake
  rpg_bus_state_t bus_state;
  rpg_bus_state_t next_bus_state;
  logic [19:0]    bus_idx;
  logic           bus_req;
  logic           bus_take;
  logic           hit_iaw;
  logic           hit_par;
  logic           hit_bitop;
  logic           bus_mapped;
  logic           wr_byte0;

  assign bus_idx    = avs_address[RPG_BUS_ADDR_W-1:2];
  assign bus_req    = avs_read || avs_write;
  assign hit_iaw    = (bus_idx == RPG_IDX_ACCESS_GUARD);
  assign hit_par    = (bus_idx == RPG_IDX_PARITY_CTRL);
  assign hit_bitop  = (bus_idx == RPG_IDX_PARITY_BITOP);
  assign bus_mapped = hit_iaw || hit_par || hit_bitop;
  // Write lands where the master sees waitrequest low
  assign bus_take   = (bus_state == RPG_BUS_ANSWER);
  assign wr_byte0   = bus_take && avs_write && avs_byteenable[0];

  // Every request waits exactly one cycle
  always_comb begin
    case (bus_state)
      RPG_BUS_IDLE:   next_bus_state = bus_req ? RPG_BUS_ANSWER : RPG_BUS_IDLE;
      RPG_BUS_ANSWER: next_bus_state = RPG_BUS_IDLE;
      default:        next_bus_state = RPG_BUS_IDLE;
    endcase
  end

  // State and waitrequest from one flop set
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      bus_state       <= RPG_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      bus_state       <= next_bus_state;
      avs_waitrequest <= (next_bus_state != RPG_BUS_ANSWER);
    end
  end

  // Answer built in the wait cycle
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= RPG_RESP_OKAY;
    end else if (bus_state == RPG_BUS_IDLE && bus_req) begin
      avs_response <= bus_mapped ? RPG_RESP_OKAY : RPG_RESP_DECERR;
      avs_readdata <= 32'h0000_0000;  // (R25)
      if (hit_iaw) begin
        avs_readdata[RPG_IAW_EN_BIT]  <= illegal_access_detect_enable;
        avs_readdata[RPG_GRAM_HI_BIT] <= ram_guard_size[1];
        avs_readdata[RPG_GRAM_LO_BIT] <= ram_guard_size[0];
        avs_readdata[RPG_PORT_CTRL_WRITE_GUARD_BIT]   <= port_ctrl_write_guard;
        avs_readdata[RPG_IRQ_REG_WRITE_GUARD_BIT]    <= irq_reg_write_guard;
        avs_readdata[RPG_CLOCK_VOLT_PARITY_GUARD_BIT]    <= clock_volt_parity_guard;
      end else if (hit_par) begin
        avs_readdata[RPG_PAR_MASK_BIT] <= parity_reset_mask;
        avs_readdata[RPG_PAR_FLAG_BIT] <= parity_error_flag;
      end
    end
  end

  // ========================================
  // Access guard: byte writes only, enable sticks
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      illegal_access_detect_enable <= RPG_CTRL_RESET[RPG_IAW_EN_BIT];  // (R21)
      ram_guard_size               <= RPG_CTRL_RESET[RPG_GRAM_HI_BIT:RPG_GRAM_LO_BIT];
      port_ctrl_write_guard        <= RPG_CTRL_RESET[RPG_PORT_CTRL_WRITE_GUARD_BIT];
      irq_reg_write_guard          <= RPG_CTRL_RESET[RPG_IRQ_REG_WRITE_GUARD_BIT];
      clock_volt_parity_guard      <= RPG_CTRL_RESET[RPG_CLOCK_VOLT_PARITY_GUARD_BIT];
    end else if (wr_byte0 && hit_iaw) begin  // (R21)
      // Only reset clears it
      illegal_access_detect_enable <= illegal_access_detect_enable
                                      | avs_writedata[RPG_IAW_EN_BIT];  // (R19)
      ram_guard_size          <= avs_writedata[RPG_GRAM_HI_BIT:RPG_GRAM_LO_BIT]
                                 & RPG_IAW_STORE_MASK[RPG_GRAM_HI_BIT:RPG_GRAM_LO_BIT];
      port_ctrl_write_guard   <= avs_writedata[RPG_PORT_CTRL_WRITE_GUARD_BIT];
      irq_reg_write_guard     <= avs_writedata[RPG_IRQ_REG_WRITE_GUARD_BIT];
      clock_volt_parity_guard <= avs_writedata[RPG_CLOCK_VOLT_PARITY_GUARD_BIT];
    end
  end

  // ========================================
  // Parity control: byte write or bit operation
  logic       par_wr_ok;
  logic       par_byte_wr;
  logic       par_bit_wr;
  logic [2:0] bitop_num;
  logic       bitop_val;

  // Clock guard shields parity control too
  assign par_wr_ok   = !clock_volt_parity_guard;  // (R17)
  assign par_byte_wr = wr_byte0 && hit_par && par_wr_ok;  // (R10)
  assign par_bit_wr  = bus_take && avs_write && avs_byteenable[1] && avs_byteenable[0]
                       && hit_bitop && par_wr_ok;  // (R10)
  assign bitop_num   = avs_writedata[RPG_BITOP_NUM_LSB +: 3];
  assign bitop_val   = avs_writedata[RPG_BITOP_VAL_BIT];

  // Reset value zero keeps parity reset armed
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      parity_reset_mask <= RPG_CTRL_RESET[RPG_PAR_MASK_BIT];  // (R4)
    end else if (par_byte_wr) begin
      parity_reset_mask <= avs_writedata[RPG_PAR_MASK_BIT];  // (R3)
    end else if (par_bit_wr && bitop_num == 3'(RPG_PAR_MASK_BIT)) begin
      parity_reset_mask <= bitop_val;  // (R3)
    end
  end

  // Sticky flag: hardware set wins
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      parity_error_flag <= RPG_CTRL_RESET[RPG_PAR_FLAG_BIT];  // (R6)
    end else if (parity_err_evt) begin
      parity_error_flag <= 1'b1;  // (R5)
    end else if (par_byte_wr && !avs_writedata[RPG_PAR_FLAG_BIT]) begin
      parity_error_flag <= 1'b0;  // (R6)
    end else if (par_bit_wr && bitop_num == 3'(RPG_PAR_FLAG_BIT) && !bitop_val) begin
      parity_error_flag <= 1'b0;  // (R6)
    end
  end

  // ========================================
  // CPU access decode
  logic             in_ram;
  logic             in_gpr;
  logic [19:0]      ram_off;
  logic [10:0]      guard_bytes;
  logic             ram_guarded;
  logic             port_blocked;
  logic             irq_blocked;
  logic             clk_blocked;
  logic             is_write;
  logic             detect_on;
  rpg_access_if     acc_if ();

  assign is_write = cpu_req && (cpu_kind == RPG_WRITE);
  assign ram_off  = cpu_addr - RAM_START;
  // Product bounds from RAM parameters
  assign in_ram   = (cpu_addr >= RAM_START)
                    && (ram_off < 20'(RAM_BYTES));  // (R22)
  assign in_gpr   = (cpu_addr >= RPG_GPR_LO) && (cpu_addr <= RPG_GPR_HI);

  // Length doubles per step, 00 is none
  assign guard_bytes = (ram_guard_size == 2'b00) ? 11'h000
                       : (11'(RPG_GUARD_UNIT) << (ram_guard_size - 2'b01));  // (R12)
  assign ram_guarded = in_ram && !in_gpr
                       && (ram_off < 20'(guard_bytes));  // (R11) (R13)

  // Output data registers carved out
  assign port_blocked = port_ctrl_write_guard
                        && (cpu_addr >= RPG_PORT_CTL_LO) && (cpu_addr <= RPG_PORT_CTL_HI)
                        && !((cpu_addr >= RPG_PORT_DATA_LO)
                             && (cpu_addr <= RPG_PORT_DATA_HI));  // (R14) (R15)
  assign irq_blocked  = irq_reg_write_guard
                        && (cpu_addr >= RPG_IRQ_LO) && (cpu_addr <= RPG_IRQ_HI);  // (R16)
  assign clk_blocked  = clock_volt_parity_guard
                        && (cpu_addr >= RPG_CLK_LO) && (cpu_addr <= RPG_CLK_HI);  // (R17)

  // Strap forces detection on
  assign detect_on = illegal_access_detect_enable || wdt_on;  // (R20)

  assign acc_if.valid = cpu_req;
  assign acc_if.addr  = cpu_addr;
  assign acc_if.kind  = cpu_kind;

  rpg_region_check #(
    .N    (RPG_NUM_REGIONS),
    .LO   (RPG_REGION_LO),
    .HI   (RPG_REGION_HI),
    .DENY (RPG_REGION_DENY)
  ) u_region (
    .acc (acc_if.chk)
  );

  // ========================================
  // Stage 1: writes out, RAM reads start
  logic [7:0] par_mem [RAM_BYTES];
  logic       ram_wr_ok;

  // Dropped writes leave no trace
  assign ram_wr_ok = is_write && in_ram && !ram_guarded && !acc_if.denied;  // (R23)

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      ram_we    <= 1'b0;
      ram_re    <= 1'b0;
      ram_addr  <= '0;
      ram_wdata <= 8'h00;
    end else begin
      ram_we    <= ram_wr_ok;  // (R11)
      // Fetches and lookahead checked too
      ram_re    <= cpu_req && !is_write && in_ram;  // (R8)
      ram_addr  <= ram_off[IDX_W-1:0];
      ram_wdata <= cpu_wdata;
    end
  end

  // One parity bit per byte, in bit 0
  always_ff @(posedge core_clk) begin
    if (ram_wr_ok) begin
      par_mem[ram_off[IDX_W-1:0]] <= {7'h00, ^cpu_wdata};  // (R1)
    end
  end

  // SFR writes outside enabled guards
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      sfr_we    <= 1'b0;
      sfr_addr  <= 20'h00000;
      sfr_wdata <= 8'h00;
    end else begin
      sfr_we    <= is_write && !in_ram && !acc_if.denied
                   && !port_blocked && !irq_blocked && !clk_blocked;  // (R14) (R16) (R17)
      sfr_addr  <= cpu_addr;
      sfr_wdata <= cpu_wdata;
    end
  end

  // ========================================
  // Stage 2 and 3: RAM answer, then check
  logic             rd_wait;
  logic [IDX_W-1:0] rd_idx;
  logic             par_stored;

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      rd_wait <= 1'b0;
      rd_idx  <= '0;
    end else begin
      rd_wait <= ram_re;
      rd_idx  <= ram_addr;
    end
  end

  assign par_stored = par_mem[rd_idx][0];
  // No enable: check cannot be switched off
  assign parity_err_evt = rd_wait && ((^ram_rdata) != par_stored);  // (R1) (R2)

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      cpu_rdata  <= 8'h00;
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rvalid <= rd_wait;
      cpu_rdata  <= rd_wait ? ram_rdata : 8'h00;
    end
  end

  // ========================================
  // Internal reset requests, one-cycle pulses
  logic access_hit;

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      access_hit <= 1'b0;
    end else begin
      access_hit <= acc_if.denied && detect_on;  // (R18)
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      parity_reset_evt   <= 1'b0;
      access_reset_evt   <= 1'b0;
      internal_reset_req <= 1'b0;
    end else begin
      parity_reset_evt   <= parity_err_evt && !parity_reset_mask;  // (R3)
      access_reset_evt   <= access_hit;  // (R18)
      internal_reset_req <= (parity_err_evt && !parity_reset_mask) || access_hit;
    end
  end

endmodule // rpg_guard

//--- rtl/rpg_pkg.sv
// Constants and types of the parity and access guard
package rpg_pkg;

  // ========================================
  // Register word indices
  localparam logic [19:0] RPG_IDX_ACCESS_GUARD = 20'hF0078;
  localparam logic [19:0] RPG_IDX_PARITY_CTRL  = 20'hF00F5;
  localparam logic [19:0] RPG_IDX_PARITY_BITOP = 20'hF00F6;
  localparam int          RPG_BUS_ADDR_W       = 22;
  localparam logic [7:0]  RPG_CTRL_RESET       = 8'h00;

  // ========================================
  // Field positions
  localparam int          RPG_PAR_MASK_BIT   = 7;
  localparam int          RPG_PAR_FLAG_BIT   = 0;
  localparam int          RPG_IAW_EN_BIT     = 7;
  localparam int          RPG_GRAM_HI_BIT    = 5;
  localparam int          RPG_GRAM_LO_BIT    = 4;
  localparam int          RPG_PORT_CTRL_WRITE_GUARD_BIT      = 2;
  localparam int          RPG_IRQ_REG_WRITE_GUARD_BIT       = 1;
  localparam int          RPG_CLOCK_VOLT_PARITY_GUARD_BIT       = 0;
  localparam logic [7:0]  RPG_IAW_STORE_MASK = 8'h37;
  localparam int          RPG_BITOP_NUM_LSB  = 0;
  localparam int          RPG_BITOP_VAL_BIT  = 8;

  // ========================================
  // Memory map defaults
  localparam logic [19:0] RPG_RAM_START    = 20'hFF900;
  localparam int          RPG_RAM_BYTES    = 1536;
  localparam logic [19:0] RPG_GPR_LO       = 20'hFFEE0;
  localparam logic [19:0] RPG_GPR_HI       = 20'hFFEFF;
  localparam logic [9:0]  RPG_GUARD_UNIT   = 10'h080;
  localparam logic [19:0] RPG_PORT_CTL_LO  = 20'hF0010;
  localparam logic [19:0] RPG_PORT_CTL_HI  = 20'hF007F;
  localparam logic [19:0] RPG_PORT_DATA_LO = 20'hF0060;
  localparam logic [19:0] RPG_PORT_DATA_HI = 20'hF006F;
  localparam logic [19:0] RPG_IRQ_LO       = 20'hFFFD0;
  localparam logic [19:0] RPG_IRQ_HI       = 20'hFFFEF;
  localparam logic [19:0] RPG_CLK_LO       = 20'hFFFA0;
  localparam logic [19:0] RPG_CLK_HI       = 20'hFFFAF;

  // ========================================
  // Access kinds, one-hot for deny masks
  typedef enum logic [2:0] {
    RPG_FETCH = 3'b001,
    RPG_READ  = 3'b010,
    RPG_WRITE = 3'b100
  } rpg_kind_t;

  // Prohibited region table: entry i sits at slice i
  localparam int RPG_NUM_REGIONS = 6;
  localparam logic [RPG_NUM_REGIONS*20-1:0] RPG_REGION_LO =
    {20'hFFF00, 20'hF4000, 20'hF1000, 20'hF0800, 20'hF0000, 20'h02000};
  localparam logic [RPG_NUM_REGIONS*20-1:0] RPG_REGION_HI =
    {20'hFFFFF, 20'hFF8FF, 20'hF3FFF, 20'hF0FFF, 20'hF07FF, 20'hEFFFF};
  localparam logic [RPG_NUM_REGIONS*3-1:0] RPG_REGION_DENY =
    {3'b001, 3'b011, 3'b100, 3'b001, 3'b001, 3'b111};

  // ========================================
  // Avalon answer codes and bus states
  localparam logic [1:0] RPG_RESP_OKAY   = 2'b00;
  localparam logic [1:0] RPG_RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    RPG_BUS_IDLE   = 2'b01,
    RPG_BUS_ANSWER = 2'b10
  } rpg_bus_state_t;

endpackage

//--- rtl/rpg_region_check.sv
// Prohibited region checker over a range table
`timescale 1ns/1ns
module rpg_region_check import rpg_pkg::*; #(
  parameter int                  N    = RPG_NUM_REGIONS,
  parameter logic [N*20-1:0]     LO   = RPG_REGION_LO,
  parameter logic [N*20-1:0]     HI   = RPG_REGION_HI,
  parameter logic [N*3-1:0]      DENY = RPG_REGION_DENY
) (
  rpg_access_if.chk acc
);

  logic [N-1:0] hit_vec;

  // ========================================
  // One comparator pair per table entry
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_region
      assign hit_vec[i] = acc.valid
                          && (acc.addr >= LO[i*20 +: 20])
                          && (acc.addr <= HI[i*20 +: 20])
                          && (|(acc.kind & DENY[i*3 +: 3]));  // (R24)
    end
  endgenerate

  assign acc.denied = |hit_vec;  // (R18)

endmodule // rpg_region_check

//--- verification/rpg_guard_props.sv
// Port-level assertions for the RAM parity and access guard
`timescale 1ns/1ns
module rpg_guard_props import rpg_pkg::*; #(
  parameter int IDX_W = $clog2(RPG_RAM_BYTES)
) (
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic [21:0]      avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_readdata,
  input wire logic [1:0]       avs_response,
  input wire logic             avs_waitrequest,
  input wire logic             cpu_req,
  input wire rpg_kind_t        cpu_kind,
  input wire logic [19:0]      cpu_addr,
  input wire logic [7:0]       cpu_wdata,
  input wire logic             cpu_rvalid,
  input wire logic             ram_we,
  input wire logic             ram_re,
  input wire logic [IDX_W-1:0] ram_addr,
  input wire logic [7:0]       ram_wdata,
  input wire logic             sfr_we,
  input wire logic [19:0]      sfr_addr,
  input wire logic             internal_reset_req,
  input wire logic             parity_reset_evt,
  input wire logic             access_reset_evt
);
  // ==============================
  // Decodes of the current request
  logic in_ram;
  logic reg_hit;
  assign in_ram = cpu_addr >= RPG_RAM_START && cpu_addr - RPG_RAM_START < 20'(RPG_RAM_BYTES);
  assign reg_hit = avs_address[21:2] inside
    {RPG_IDX_ACCESS_GUARD, RPG_IDX_PARITY_CTRL, RPG_IDX_PARITY_BITOP};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==============================
  // Bus answer, decode and CPU path relations
  wait_one_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
  ) else $error("answer late");
  wait_pulse_a: assert property (
    !avs_waitrequest |=> avs_waitrequest
  ) else $error("answer too long");
  dec_err_a: assert property (
    !avs_waitrequest && !reg_hit |-> avs_response == RPG_RESP_DECERR && avs_readdata == 0
  ) else $error("no decode error");
  read_pass_a: assert property (
    cpu_req && cpu_kind == RPG_READ && in_ram
      |=> ram_re && ram_addr == IDX_W'($past(cpu_addr) - RPG_RAM_START)
  ) else $error("RAM read lost");
  ram_wr_a: assert property (
    ram_we |-> $past(cpu_req) && $past(cpu_kind) == RPG_WRITE && ram_wdata == $past(cpu_wdata)
  ) else $error("stray RAM write");
  rvalid_lat_a: assert property (
    ram_re |-> ##2 cpu_rvalid
  ) else $error("no read data");
  stray_rv_a: assert property (
    cpu_rvalid |-> $past(ram_re, 2)
  ) else $error("stray read data");
  port_data_a: assert property (
    cpu_req && cpu_kind == RPG_WRITE && cpu_addr inside {[RPG_PORT_DATA_LO:RPG_PORT_DATA_HI]}
      |=> sfr_we && sfr_addr == $past(cpu_addr)
  ) else $error("port data blocked");
  cause_a: assert property (
    internal_reset_req == (parity_reset_evt || access_reset_evt)
  ) else $error("reset without cause");
  acc_src_a: assert property (
    access_reset_evt |-> $past(cpu_req, 2) && !$past(in_ram, 2)
  ) else $error("stray access reset");
endmodule // rpg_guard_props

//--- verification/rpg_guard_tb.sv
// Self-checking bench for the RAM parity and access guard
`timescale 1ns/1ns
module rpg_guard_tb import rpg_pkg::*; ();
  localparam logic [21:0] AG = 22'h3C01E0;
  localparam logic [21:0] PC = 22'h3C03D4;
  localparam logic [21:0] BO = 22'h3C03D8;
  localparam logic [19:0] RS = RPG_RAM_START;
  logic        core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        cpu_req = 1'b0, watchdog_option_on = 1'b0, flip = 1'b0;
  logic [21:0] avs_address = '0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = '0;
  rpg_kind_t   cpu_kind = RPG_READ;
  logic [19:0] cpu_addr = '0;
  logic [7:0]  cpu_wdata = '0;
  logic [31:0] avs_readdata;
  logic [1:0]  avs_response;
  logic        avs_waitrequest, cpu_rvalid, ram_we, ram_re, sfr_we;
  logic        internal_reset_req, parity_reset_evt, access_reset_evt;
  logic [7:0]  cpu_rdata, ram_wdata, ram_rdata, sfr_wdata, d;
  logic [10:0] ram_addr;
  logic [19:0] sfr_addr;
  logic [31:0] seed = 32'h2CC66FB1;
  logic [31:0] reg_q[$];
  logic [7:0]  cpu_q[$];
  logic [7:0]  sh[int];
  logic [19:0] sa[4] = '{20'hF0010, 20'hF0060, 20'hFFFD0, 20'hFFFA0};
  int          sg[4] = '{2, -1, 1, 0};
  int error_cnt = 0, comparisons = 0, cyc = 0, lim;
  int n_par = 0, n_acc = 0, n_rst = 0, n_sfr = 0, e_par = 0, e_acc = 0, e_sfr = 0;

  rpg_guard rpg_guard_inst (.*);
  rpg_ram_model rpg_ram_model_inst (.*);

  initial forever #5 core_clk = ~core_clk;

  // ==============================
  // Shared tasks
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask
  // Hold until waitrequest low, then idle a cycle
  task automatic bus(input logic w, input logic [21:0] a, input logic [31:0] dt,
                     input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= dt;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [21:0] a, input logic [7:0] v);
    bus(1'b1, a, {24'h0, v}, 4'hF);
  endtask
  task automatic rd(input logic [21:0] a, input logic [7:0] e);
    reg_q.push_back({24'h0, e});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  // One CPU access, then time for its pulses
  task automatic cpu(input rpg_kind_t k, input logic [19:0] a, input logic [7:0] v);
    cpu_req <= 1'b1;
    cpu_kind <= k;
    cpu_addr <= a;
    cpu_wdata <= v;
    @(posedge core_clk);
    cpu_req <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic cw(input logic [19:0] a, input logic ok);
    d = rnd();
    cpu(RPG_WRITE, a, d);
    if (ok) sh[a] = d;
  endtask
  task automatic rc(input logic [19:0] a, input rpg_kind_t k, input logic f = 1'b0);
    flip <= f;
    cpu_q.push_back(sh[a] ^ {7'h00, f});
    cpu(k, a, 8'h00);
  endtask

  // ==============================
  // Watcher pops the oldest note per result
  always @(posedge core_clk) begin
    cyc++;
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, reg_q.pop_front());
    if (cpu_rvalid === 1'b1) chk({24'h0, cpu_rdata}, {24'h0, cpu_q.pop_front()});
    n_par += (parity_reset_evt === 1'b1);
    n_acc += (access_reset_evt === 1'b1);
    n_rst += (internal_reset_req === 1'b1);
    n_sfr += (sfr_we === 1'b1);
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  // ==============================
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(PC, 8'h00);
    rd(AG, 8'h00);
    rd(22'h000100, 8'h00);
    chk({30'h0, avs_response}, {30'h0, RPG_RESP_DECERR});
    $display("reset values done");
    cw(RS, 1'b1);
    cw(RS + 20'h1, 1'b1);
    rc(RS, RPG_READ);
    rc(RS + 20'h1, RPG_READ, 1'b1);
    e_par++;
    chk(n_par, e_par);
    rd(PC, 8'h01);
    rc(RS, RPG_READ);
    rd(PC, 8'h01);
    wr(PC, 8'h01);
    rd(PC, 8'h01);
    bus(1'b1, BO, {23'h0, 1'b1, 5'h0, 3'd7}, 4'h3);
    rd(PC, 8'h81);
    wr(PC, 8'h80);
    rd(PC, 8'h80);
    rc(RS + 20'h1, RPG_FETCH, 1'b1);
    rd(PC, 8'h81);
    chk(n_par, e_par);
    wr(PC, 8'h00);
    $display("parity done");
    for (int g = 1; g < 4; g++) cw(RS + 20'(128 << (g - 1)) - 20'h1, 1'b1);
    for (int g = 1; g < 4; g++) begin
      lim = 128 << (g - 1);
      wr(AG, 8'(g << 4));
      cw(RS + 20'(lim) - 20'h1, 1'b0);
      cw(RS + 20'(lim), 1'b1);
      rc(RS + 20'(lim) - 20'h1, RPG_READ);
      rc(RS + 20'(lim), RPG_READ);
    end
    cw(RPG_GPR_LO, 1'b1);
    rc(RPG_GPR_LO, RPG_READ);
    $display("RAM guard done");
    for (int b = 2; b >= 0; b--) begin
      wr(AG, 8'(1 << b));
      for (int i = 0; i < 4; i++) begin
        cw(sa[i], 1'b0);
        e_sfr += (sg[i] != b);
      end
    end
    chk(n_sfr, e_sfr);
    wr(PC, 8'h80);
    rd(PC, 8'h00);
    $display("register guard done");
    wr(AG, 8'h00);
    cpu(RPG_FETCH, 20'hF0000, 8'h00);
    chk(n_acc, e_acc);
    wr(AG, 8'h80);
    wr(AG, 8'h00);
    rd(AG, 8'h80);
    cpu(RPG_FETCH, 20'hF0000, 8'h00);
    cpu(RPG_WRITE, 20'h02000, rnd());
    cpu(RPG_READ, 20'hF4000, 8'h00);
    cpu(RPG_READ, 20'hF1000, 8'h00);
    e_acc += 3;
    chk(n_acc, e_acc);
    $display("access detection done");
    watchdog_option_on <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(AG, 8'h00);
    cpu(RPG_READ, 20'hF4000, 8'h00);
    e_acc++;
    chk(n_acc, e_acc);
    chk(n_rst, e_acc + e_par);
    chk(reg_q.size() + cpu_q.size(), 0);
    $display("watchdog option done");
    close_out();
  end
endmodule // rpg_guard_tb

bind rpg_guard rpg_guard_props #(.IDX_W(IDX_W)) rpg_guard_props_inst (.*);

//--- verification/rpg_ram_model.sv
// Byte RAM model with bit-flip injection
`timescale 1ns/1ns
module rpg_ram_model #(
  parameter int AW = 11
) (
  input  wire logic          core_clk,
  input  wire logic          ram_we,
  input  wire logic          ram_re,
  input  wire logic [AW-1:0] ram_addr,
  input  wire logic [7:0]    ram_wdata,
  input  wire logic          flip,
  output logic [7:0]         ram_rdata
);
  logic [7:0] mem [2**AW];
  logic [7:0] q = 8'hA5;
  assign ram_rdata = q;
  // Registered read; idle bus toggles
  always_ff @(posedge core_clk) begin
    if (ram_we) mem[ram_addr] <= ram_wdata;
    if (ram_re) q <= mem[ram_addr] ^ {7'h00, flip};
    else q <= ~q;
  end
endmodule // rpg_ram_model
